// ### tmo_top.sv
// tmo_top: tachometer measurement, comparison outputs, monitors and mode entry
// Summary of operation
// - in cycle mode, no pulse within auto-zero time forces measurement to zero; pulses restart it
// - after power-up, no measuring and outputs off until startup time passes
// - with hold enabled track peak and bottom since counting start
// - held peak survives a power interruption
// - hysteresis is in measurement units and stops output chatter near set values, except in band mode
// - output turn-off is postponed by the off delay; measuring continues
// - set values written in run mode are clamped to a limit of 1 to 999999
// - colour fixed red, fixed green, or switched by any output being on
// - in band mode dynamic colour follows output one only
// - allocation swaps the two physical output drivers
// - each output has its own normally-open or normally-closed inversion
// - pulse cycle mode reports pulses per second
// - width mode measures one pulse on-time; off time of 20 ms needed
// - width mode keeps last width when pulses stop
// - cycle mode uses 200 ms interval or continuous 10 ms interval
// - on events of each output are counted, shown divided by 1000
// - run time accumulates with 0.1 year resolution
// - measurement compared with both set values per output mode
// - reset key or reset 1 release clears held values; reset 2 in two-input mode
// - config mode entered only by mode key held then up1 held 1 s
// - config mode entry resets value, turns outputs off, stops measuring
// - config changes apply on return to run and reinitialise set values
// - cycle mode measurement sampled every 200 ms, or every 10 ms when continuous
module tmo_top
  import tmo_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS,
  parameter int unsigned TENTH_YEAR_SEC = TENTH_YEAR_S,
  parameter int MW = MEAS_W
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic sensor_in,
  input wire logic reset_key_in,
  input wire logic reset1_in,
  input wire logic reset2_in,
  input wire logic mode_key_in,
  input wire logic up1_key_in,
  output logic first_control_output,
  output logic second_control_output,
  output logic colour_green,
  output logic cfg_mode
);
  localparam int DW = $clog2(MS_CYCLES);
  localparam int YW = $clog2(TENTH_YEAR_SEC);

  logic [NIN-1:0] pin_raw, s1_r, s2_r, p_r, rise, fall;
  logic [DW-1:0] div_r, div_nxt;
  logic tick;
  tmo_state_e st_r, st_nxt;
  logic [TMR_W-1:0] hold_r, hold_nxt, su_r, su_nxt, az_r, az_nxt, gate_r, gate_nxt;
  logic [4:0] off_r, off_nxt;
  logic su_done_r, su_done_nxt, arm_w_r, arm_w_nxt;
  logic [MW-1:0] pcnt_r, pcnt_nxt, wid_r, wid_nxt, meas_r, meas_nxt, bot_r, bot_nxt;
  logic [MW-1:0] peak_r, peak_nxt, newv, sv1_r, sv1_nxt, sv2_r, sv2_nxt, lim_r, lim_nxt;
  logic [MW-1:0] hyst_r, hyst_nxt, wv;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt, pend_r, pend_nxt;
  logic [TMR_W-1:0] offd_r, offd_nxt, azt_r, azt_nxt, sut_r, sut_nxt;
  logic [1:0] cmp, q_r, q_nxt;
  logic [1:0][TMR_W-1:0] dly_r, dly_nxt;
  logic [1:0][9:0] lo_r, lo_nxt;
  logic [1:0][MW-1:0] k_r, k_nxt;
  logic [9:0] sec_r, sec_nxt;
  logic [YW-1:0] ys_r, ys_nxt;
  logic [TMR_W-1:0] yr_r, yr_nxt;
  logic outa_r, outa_nxt, outb_r, outb_nxt, green_r, green_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic upd, clr_hold, measuring, area, any_on, en, gate_end;
  logic [1:0] mode, colsel;
  logic [TMR_W-1:0] gate_ms;
  logic [MW:0] m_x, s_x, h_x, lo_b, hi_b;

  assign pin_raw = {up1_key_in, mode_key_in, reset2_in, reset1_in, reset_key_in, sensor_in};

  // two-stage synchronisers; the second stage and its one-cycle delayed copy p_r feed logic
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          p_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          p_r[gi] <= s2_r[gi];
        end
      end
      assign rise[gi] = s2_r[gi] & ~p_r[gi];
      assign fall[gi] = ~s2_r[gi] & p_r[gi];
    end
  endgenerate

  assign tick = (div_r == DW'(MS_CYCLES - 1));
  assign mode = ctrl_r[CB_MODE +: 2];
  assign colsel = ctrl_r[CB_COL +: 2];
  assign area = (mode == OM_AREA);
  assign measuring = su_done_r && (st_r != ST_CFG);
  assign en = su_done_r && (st_r == ST_RUN);
  // continuous interval only shortens the gate; scaling keeps pulses per second
  assign gate_ms = ctrl_r[CB_CONT] ? TMR_W'(CONT_MS) : TMR_W'(SAMPLE_MS);
  // a gate left long by a switch to the short interval ends at the next tick, not after wrap
  assign gate_end = tick && (gate_r >= gate_ms - TMR_W'(1));
  assign m_x = {1'b0, meas_r};
  assign h_x = {1'b0, hyst_r};
  assign lo_b = (sv1_r < sv2_r) ? {1'b0, sv1_r} : {1'b0, sv2_r};
  assign hi_b = (sv1_r < sv2_r) ? {1'b0, sv2_r} : {1'b0, sv1_r};
  assign wv = (reg_wdata[MW-1:0] > lim_r) ? lim_r : reg_wdata[MW-1:0];
  assign any_on = area ? q_r[0] : (q_r[0] | q_r[1]);

  always_comb begin
    div_nxt = tick ? '0 : DW'(div_r + DW'(1));
    st_nxt = st_r;
    hold_nxt = hold_r;
    su_nxt = su_r;
    su_done_nxt = su_done_r;
    az_nxt = az_r;
    gate_nxt = gate_r;
    off_nxt = off_r;
    arm_w_nxt = arm_w_r;
    pcnt_nxt = pcnt_r;
    wid_nxt = wid_r;
    meas_nxt = meas_r;
    bot_nxt = bot_r;
    peak_nxt = peak_r;
    sv1_nxt = sv1_r;
    sv2_nxt = sv2_r;
    lim_nxt = lim_r;
    hyst_nxt = hyst_r;
    ctrl_nxt = ctrl_r;
    pend_nxt = pend_r;
    offd_nxt = offd_r;
    azt_nxt = azt_r;
    sut_nxt = sut_r;
    upd = 1'b0;
    newv = meas_r;
    clr_hold = 1'b0;
    // startup inhibit counted in ms after reset release
    if (!su_done_r && tick) begin
      su_nxt = su_r + TMR_W'(1);
      if (su_r >= sut_r) su_done_nxt = 1'b1;
    end
    // configuration selection entry and exit
    case (st_r)
      ST_RUN: begin
        if (s2_r[IN_MODE] && rise[IN_UP1]) begin
          st_nxt = ST_ARM;
          hold_nxt = '0;
        end
      end
      ST_ARM: begin
        if (!(s2_r[IN_MODE] && s2_r[IN_UP1])) begin
          st_nxt = ST_RUN;
        end else if (tick) begin
          hold_nxt = hold_r + TMR_W'(1);
          if (hold_r == TMR_W'(CFG_HOLD_MS - 1)) st_nxt = ST_CFG;
        end
      end
      ST_CFG: begin
        if (rise[IN_MODE]) begin
          st_nxt = ST_RUN;
          if (pend_r != ctrl_r) begin
            ctrl_nxt = pend_r;
            sv1_nxt = SV1_RST;
            sv2_nxt = SV2_RST;
            clr_hold = 1'b1;
          end
        end
      end
      default: st_nxt = ST_RUN;
    endcase
    // measurement
    if (tick && off_r != 5'h1f && !s2_r[IN_SENS]) off_nxt = off_r + 5'h01;
    if (rise[IN_SENS]) off_nxt = '0;
    if (st_nxt == ST_CFG && st_r != ST_CFG) begin
      meas_nxt = '0;
      pcnt_nxt = '0;
      gate_nxt = '0;
    end else if (measuring) begin
      if (rise[IN_SENS]) az_nxt = '0;
      else if (tick && az_r != '1) az_nxt = az_r + TMR_W'(1);
      if (!ctrl_r[CB_WIDTH]) begin
        if (tick) gate_nxt = gate_end ? '0 : gate_r + TMR_W'(1);
        pcnt_nxt = gate_end ? MW'(rise[IN_SENS]) : pcnt_r + MW'(rise[IN_SENS]);
        if (gate_end) begin
          upd = 1'b1;
          newv = MW'(pcnt_r * (MS_PER_S / gate_ms));
        end
        if (azt_r != '0 && az_r >= azt_r) begin
          newv = '0;
          upd = 1'b1;
        end
      end else begin
        // a width starts only after the required off interval
        if (rise[IN_SENS]) arm_w_nxt = (off_r >= 5'(MIN_OFF_MS));
        if (s2_r[IN_SENS] && tick) wid_nxt = wid_r + MW'(1);
        if (rise[IN_SENS]) wid_nxt = MW'(tick);
        if (fall[IN_SENS] && arm_w_r) begin
          upd = 1'b1;
          newv = wid_r;
        end
      end
      if (upd) meas_nxt = newv;
      if (upd && ctrl_r[CB_PEAK]) begin
        if (newv > peak_r) peak_nxt = newv;
        if (newv < bot_r) bot_nxt = newv;
      end
    end
    if (ctrl_r[CB_PEAK] && (fall[IN_RKEY] || fall[IN_RST1] || (ctrl_r[CB_TWO] && fall[IN_RST2])))
      clr_hold = 1'b1;
    // register writes; a write to the control word in run mode is a function change
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          pend_nxt = reg_wdata[CTRL_W-1:0];
          if (st_r != ST_CFG) begin
            ctrl_nxt = reg_wdata[CTRL_W-1:0];
            clr_hold = 1'b1;
          end
        end
        OFS_SV1: sv1_nxt = wv;
        OFS_SV2: sv2_nxt = wv;
        OFS_LIMIT: lim_nxt = (reg_wdata[MW-1:0] < LIM_MIN) ? LIM_MIN :
                             (reg_wdata[MW-1:0] > LIM_RST) ? LIM_RST : reg_wdata[MW-1:0];
        OFS_HYST: hyst_nxt = reg_wdata[MW-1:0];
        OFS_OFFDLY: offd_nxt = reg_wdata[TMR_W-1:0];
        OFS_AZERO: azt_nxt = reg_wdata[TMR_W-1:0];
        OFS_START: sut_nxt = reg_wdata[TMR_W-1:0];
        default: ;
      endcase
    end
    if (clr_hold) begin
      peak_nxt = '0;
      bot_nxt = '1;
    end
  end

  // comparison, off delay, inversion, allocation and colour
  always_comb begin
    q_nxt = q_r;
    dly_nxt = dly_r;
    for (int i = 0; i < 2; i++) begin
      s_x = i == 0 ? {1'b0, sv1_r} : {1'b0, sv2_r};
      if (area) begin
        cmp[i] = (i == 0) && (m_x >= lo_b) && (m_x <= hi_b);
      end else if (mode == OM_HIHI || (mode == OM_HILO && i == 0)) begin
        // upper limit: release only below set value minus hysteresis
        cmp[i] = q_r[i] ? (m_x + h_x >= s_x) : (m_x >= s_x);
      end else begin
        cmp[i] = q_r[i] ? (m_x <= s_x + h_x) : (m_x <= s_x);
      end
      if (!en) begin
        q_nxt[i] = 1'b0;
        dly_nxt[i] = '0;
      end else if (cmp[i]) begin
        q_nxt[i] = 1'b1;
        dly_nxt[i] = offd_r;
      end else if (q_r[i] && dly_r[i] != '0) begin
        if (tick) dly_nxt[i] = dly_r[i] - TMR_W'(1);
      end else begin
        q_nxt[i] = 1'b0;
      end
    end
    // disabled outputs are de-energised regardless of inversion
    outa_nxt = en && ((ctrl_r[CB_ALLOC] ? q_nxt[1] : q_nxt[0]) ^
               (ctrl_r[CB_ALLOC] ? ctrl_r[CB_INV2] : ctrl_r[CB_INV1]));
    outb_nxt = en && ((ctrl_r[CB_ALLOC] ? q_nxt[0] : q_nxt[1]) ^
               (ctrl_r[CB_ALLOC] ? ctrl_r[CB_INV1] : ctrl_r[CB_INV2]));
    case (colsel)
      COL_RED: green_nxt = 1'b0;
      COL_GRN: green_nxt = 1'b1;
      COL_RG: green_nxt = any_on;
      default: green_nxt = ~any_on;
    endcase
  end

  // on-event counters and run-time monitor
  always_comb begin
    lo_nxt = lo_r;
    k_nxt = k_r;
    for (int i = 0; i < 2; i++) begin
      if (q_nxt[i] && !q_r[i]) begin
        if (lo_r[i] == 10'(ON_DIV - 1)) begin
          lo_nxt[i] = '0;
          k_nxt[i] = k_r[i] + MW'(1);
        end else begin
          lo_nxt[i] = lo_r[i] + 10'h001;
        end
      end
    end
    sec_nxt = sec_r;
    ys_nxt = ys_r;
    yr_nxt = yr_r;
    if (tick) begin
      sec_nxt = (sec_r == 10'(MS_PER_S - 1)) ? '0 : sec_r + 10'h001;
      if (sec_r == 10'(MS_PER_S - 1)) begin
        if (ys_r == YW'(TENTH_YEAR_SEC - 1)) begin
          ys_nxt = '0;
          yr_nxt = yr_r + TMR_W'(1);
        end else begin
          ys_nxt = ys_r + YW'(1);
        end
      end
    end
    rdata_nxt = '0;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rdata_nxt = 32'(ctrl_r);
        OFS_SV1: rdata_nxt = 32'(sv1_r);
        OFS_SV2: rdata_nxt = 32'(sv2_r);
        OFS_LIMIT: rdata_nxt = 32'(lim_r);
        OFS_HYST: rdata_nxt = 32'(hyst_r);
        OFS_OFFDLY: rdata_nxt = 32'(offd_r);
        OFS_AZERO: rdata_nxt = 32'(azt_r);
        OFS_START: rdata_nxt = 32'(sut_r);
        OFS_MEAS: rdata_nxt = 32'(meas_r);
        OFS_PEAK: rdata_nxt = 32'(peak_r);
        OFS_BOTTOM: rdata_nxt = 32'(bot_r);
        OFS_ONCNT1: rdata_nxt = 32'(k_r[0]);
        OFS_ONCNT2: rdata_nxt = 32'(k_r[1]);
        OFS_RUNTIME: rdata_nxt = 32'(yr_r);
        OFS_STATUS: rdata_nxt = {24'h000000, st_r, su_done_r, green_r, q_r, 1'b0};
        OFS_PEND: rdata_nxt = 32'(pend_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      st_r <= ST_RUN;
      hold_r <= '0;
      su_r <= '0;
      su_done_r <= 1'b0;
      az_r <= '0;
      gate_r <= '0;
      off_r <= '0;
      arm_w_r <= 1'b0;
      pcnt_r <= '0;
      wid_r <= '0;
      meas_r <= '0;
      bot_r <= '1;
      sv1_r <= SV1_RST;
      sv2_r <= SV2_RST;
      lim_r <= LIM_RST;
      hyst_r <= '0;
      ctrl_r <= CTRL_RST;
      pend_r <= CTRL_RST;
      offd_r <= TMR_RST;
      azt_r <= TMR_RST;
      sut_r <= TMR_RST;
      q_r <= '0;
      dly_r <= '0;
      lo_r <= '0;
      k_r <= '0;
      sec_r <= '0;
      ys_r <= '0;
      yr_r <= '0;
      outa_r <= 1'b0;
      outb_r <= 1'b0;
      green_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      div_r <= div_nxt;
      st_r <= st_nxt;
      hold_r <= hold_nxt;
      su_r <= su_nxt;
      su_done_r <= su_done_nxt;
      az_r <= az_nxt;
      gate_r <= gate_nxt;
      off_r <= off_nxt;
      arm_w_r <= arm_w_nxt;
      pcnt_r <= pcnt_nxt;
      wid_r <= wid_nxt;
      meas_r <= meas_nxt;
      bot_r <= bot_nxt;
      sv1_r <= sv1_nxt;
      sv2_r <= sv2_nxt;
      lim_r <= lim_nxt;
      hyst_r <= hyst_nxt;
      ctrl_r <= ctrl_nxt;
      pend_r <= pend_nxt;
      offd_r <= offd_nxt;
      azt_r <= azt_nxt;
      sut_r <= sut_nxt;
      q_r <= q_nxt;
      dly_r <= dly_nxt;
      lo_r <= lo_nxt;
      k_r <= k_nxt;
      sec_r <= sec_nxt;
      ys_r <= ys_nxt;
      yr_r <= yr_nxt;
      outa_r <= outa_nxt;
      outb_r <= outb_nxt;
      green_r <= green_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // peak has no reset so it rides through a supply dip like backed-up storage
  always_ff @(posedge clk) begin
    peak_r <= peak_nxt;
  end

  assign first_control_output = outa_r;
  assign second_control_output = outb_r;
  assign colour_green = green_r;
  assign cfg_mode = (st_r == ST_CFG);
  assign reg_rdata = rdata_r;

  property p_autozero;
    @(posedge clk) disable iff (!nrst)
    (measuring && !ctrl_r[CB_WIDTH] && azt_r != '0 && az_r >= azt_r && st_nxt != ST_CFG)
      |=> (meas_r == '0);
  endproperty
  a_autozero: assert property (p_autozero) else $error("auto-zero did not clear value");

  property p_startup;
    @(posedge clk) disable iff (!nrst)
    !su_done_r |=> (!outa_r && !outb_r && q_r == 2'b00);
  endproperty
  a_startup: assert property (p_startup) else $error("output active during startup");

  property p_peak;
    @(posedge clk) disable iff (!nrst)
    (upd && measuring && ctrl_r[CB_PEAK] && !clr_hold && newv > peak_r) |=> (peak_r == $past(newv));
  endproperty
  a_peak: assert property (p_peak) else $error("peak not tracked");

  property p_offdly;
    @(posedge clk) disable iff (!nrst)
    (en && st_nxt == ST_RUN && q_r[0] && !cmp[0] && dly_r[0] != '0) |=> q_r[0];
  endproperty
  a_offdly: assert property (p_offdly) else $error("output dropped inside off delay");

  property p_clamp;
    @(posedge clk) disable iff (!nrst)
    (reg_wr && reg_addr == OFS_SV1 && st_r == ST_RUN && reg_wdata[MW-1:0] > lim_r)
      |=> (sv1_r == $past(lim_r));
  endproperty
  a_clamp: assert property (p_clamp) else $error("set value exceeds limit");

  property p_red;
    @(posedge clk) disable iff (!nrst)
    (colsel == COL_RED) ##1 (colsel == COL_RED) |-> !colour_green;
  endproperty
  a_red: assert property (p_red) else $error("fixed red shows green");

  property p_cfg_entry;
    @(posedge clk) disable iff (!nrst)
    (st_r == ST_ARM && st_nxt == ST_CFG) |=> (meas_r == '0) ##1 (!outa_r && !outb_r);
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) else $error("config entry left state active");

  property p_oncnt;
    @(posedge clk) disable iff (!nrst)
    (q_nxt[0] && !q_r[0] && lo_r[0] == 10'(ON_DIV - 1)) |=> (k_r[0] == $past(k_r[0]) + MW'(1));
  endproperty
  a_oncnt: assert property (p_oncnt) else $error("on count thousands missed");

  property p_hold_upper;
    @(posedge clk) disable iff (!nrst)
    (en && mode == OM_HIHI && q_r[0] && m_x + h_x >= {1'b0, sv1_r}) |=> q_r[0];
  endproperty
  a_hold_upper: assert property (p_hold_upper) else $error("upper output released early");
endmodule

// ### tmo_pkg.sv
// tmo_pkg: constants, register map and types of the tachometer measure/output block
package tmo_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int ADDR_W = 6;
  localparam int MEAS_W = 20;
  localparam int TMR_W = 16;
  localparam int CTRL_W = 11;
  // register byte offsets
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SV1 = 6'h04;
  localparam logic [5:0] OFS_SV2 = 6'h08;
  localparam logic [5:0] OFS_LIMIT = 6'h0c;
  localparam logic [5:0] OFS_HYST = 6'h10;
  localparam logic [5:0] OFS_OFFDLY = 6'h14;
  localparam logic [5:0] OFS_AZERO = 6'h18;
  localparam logic [5:0] OFS_START = 6'h1c;
  localparam logic [5:0] OFS_MEAS = 6'h20;
  localparam logic [5:0] OFS_PEAK = 6'h24;
  localparam logic [5:0] OFS_BOTTOM = 6'h28;
  localparam logic [5:0] OFS_ONCNT1 = 6'h2c;
  localparam logic [5:0] OFS_ONCNT2 = 6'h30;
  localparam logic [5:0] OFS_RUNTIME = 6'h34;
  localparam logic [5:0] OFS_STATUS = 6'h38;
  localparam logic [5:0] OFS_PEND = 6'h3c;
  // control field positions
  localparam int CB_WIDTH = 0;
  localparam int CB_MODE = 1;
  localparam int CB_COL = 3;
  localparam int CB_ALLOC = 5;
  localparam int CB_INV1 = 6;
  localparam int CB_INV2 = 7;
  localparam int CB_PEAK = 8;
  localparam int CB_CONT = 9;
  localparam int CB_TWO = 10;
  localparam logic [1:0] OM_HILO = 2'h0;
  localparam logic [1:0] OM_AREA = 2'h1;
  localparam logic [1:0] OM_HIHI = 2'h2;
  localparam logic [1:0] OM_LOLO = 2'h3;
  localparam logic [1:0] COL_RED = 2'h0;
  localparam logic [1:0] COL_GRN = 2'h1;
  localparam logic [1:0] COL_RG = 2'h2;
  localparam logic [1:0] COL_GR = 2'h3;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam logic [MEAS_W-1:0] SV1_RST = 20'h003e8;
  localparam logic [MEAS_W-1:0] SV2_RST = 20'h001f4;
  localparam logic [MEAS_W-1:0] LIM_MIN = 20'h00001;
  localparam logic [MEAS_W-1:0] LIM_RST = 20'hf423f;
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  // timing, in milliseconds unless named otherwise
  localparam int unsigned SAMPLE_MS = 200;
  localparam int unsigned CONT_MS = 10;
  localparam int unsigned CFG_HOLD_MS = 1000;
  localparam int unsigned MIN_OFF_MS = 20;
  localparam int unsigned ON_DIV = 1000;
  localparam int unsigned TENTH_YEAR_S = 3155760;
  // synchronised pin indices
  localparam int NIN = 6;
  localparam int IN_SENS = 0;
  localparam int IN_RKEY = 1;
  localparam int IN_RST1 = 2;
  localparam int IN_RST2 = 3;
  localparam int IN_MODE = 4;
  localparam int IN_UP1 = 5;
  typedef enum logic [2:0] {ST_RUN = 3'b001, ST_ARM = 3'b010, ST_CFG = 3'b100} tmo_state_e;
endpackage

// ### tmo_sensor.sv
// tmo_sensor: pulse sensor model driving the tachometer input
module tmo_sensor #(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic clk,
  input wire logic en,
  input wire logic [31:0] on_ms,
  input wire logic [31:0] off_ms,
  output logic sensor
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  // free-running on/off pattern; the caller keeps off_ms >= 20 in width mode
  initial begin
    sensor = 1'b0;
    cnt = 0;
    forever begin
      @(posedge clk);
      #2;
      if (!en) begin
        sensor = 1'b0;
        cnt = 0;
      end else begin
        cnt = cnt + 1;
        if (sensor && cnt >= on_ms * MS_CYCLES) begin
          sensor = 1'b0;
          cnt = 0;
        end else if (!sensor && cnt >= off_ms * MS_CYCLES) begin
          sensor = 1'b1;
          cnt = 0;
        end
      end
    end
  end
endmodule

// ### tb.sv
// tb: register-level test of the tachometer measure/output block
module tb
  import tmo_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MSC = 10;
  logic clk, nrst, reg_wr, reg_rd, sensor_in, reset_key_in, reset1_in, reset2_in;
  logic mode_key_in, up1_key_in, first_control_output, second_control_output;
  logic colour_green, cfg_mode, sen_en;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  int unsigned on_ms, off_ms, cyc;
  int mismatches, samples_checked;
  logic [CTRL_W-1:0] tab_ctrl [6];
  logic [2:0] tab_exp [6];
  tmo_top #(.MS_CYCLES(MSC), .TENTH_YEAR_SEC(3)) dut (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sensor_in(sensor_in), .reset_key_in(reset_key_in),
    .reset1_in(reset1_in), .reset2_in(reset2_in), .mode_key_in(mode_key_in),
    .up1_key_in(up1_key_in), .first_control_output(first_control_output),
    .second_control_output(second_control_output), .colour_green(colour_green),
    .cfg_mode(cfg_mode));
  tmo_sensor #(.MS_CYCLES(MSC)) sen (.clk(clk), .en(sen_en), .on_ms(on_ms), .off_ms(off_ms),
    .sensor(sensor_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input string name, input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(name, exp, v);
  endtask
  task automatic outs(input logic [2:0] exp);
    repeat (3) @(posedge clk);
    #1 chk("outputs", exp, {29'h0, first_control_output, second_control_output, colour_green});
  endtask
  task automatic hold_keys(input int unsigned n);
    repeat (n) @(posedge clk);
  endtask
  initial begin
    {reg_wr, reg_rd, reset_key_in, reset1_in, reset2_in, mode_key_in, up1_key_in} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    sen_en = 1'b0;
    on_ms = 1;
    off_ms = 1;
    cyc = 0;
    mismatches = 0;
    samples_checked = 0;
    tab_ctrl = '{11'h108, 11'h110, 11'h118, 11'h140, 11'h120, 11'h112};
    tab_exp = '{3'b011, 3'b011, 3'b010, 3'b110, 3'b100, 3'b101};
    nrst = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd("status early", OFS_STATUS, 32'h20);
    rd("ctrl", OFS_CTRL, 32'h0);
    rd("sv1", OFS_SV1, 32'h3e8);
    rd("sv2", OFS_SV2, 32'h1f4);
    rd("limit", OFS_LIMIT, 32'hf423f);
    rd("unmapped", 6'h02, 32'h0);
    wr(OFS_LIMIT, 32'h64);
    wr(OFS_SV1, 32'h1000);
    rd("sv1 clamp", OFS_SV1, 32'h64);
    wr(OFS_LIMIT, 32'h0);
    rd("limit min", OFS_LIMIT, 32'h1);
    wr(OFS_LIMIT, 32'hf423f);
    wr(OFS_SV1, 32'h3e8);
    wr(OFS_MEAS, 32'h55);
    rd("meas ro", OFS_MEAS, 32'h0);
    rd("status done", OFS_STATUS, 32'h34);
    wr(OFS_CTRL, 32'h100);
    sen_en <= 1'b1;
    hold_keys(4500);
    rd("meas 500 Hz", OFS_MEAS, 32'h1f4);
    rd("peak", OFS_PEAK, 32'h1f4);
    outs(3'b010);
    reset_key_in <= 1'b1;
    hold_keys(5);
    reset_key_in <= 1'b0;
    hold_keys(5);
    rd("bottom cleared", OFS_BOTTOM, 32'hfffff);
    rd("on count", OFS_ONCNT2, 32'h0);
    // colour, inversion, allocation and band cases share one table
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, {21'h0, tab_ctrl[i]});
      outs(tab_exp[i]);
    end
    wr(OFS_CTRL, 32'h0);
    wr(OFS_AZERO, 32'h5);
    sen_en <= 1'b0;
    hold_keys(200);
    rd("auto zero", OFS_MEAS, 32'h0);
    wr(OFS_AZERO, 32'h0);
    wr(OFS_CTRL, 32'h1);
    on_ms <= 5;
    off_ms <= 25;
    sen_en <= 1'b1;
    hold_keys(700);
    sen_en <= 1'b0;
    hold_keys(500);
    rd("width", OFS_MEAS, 32'h5);
    up1_key_in <= 1'b1;
    hold_keys(2);
    mode_key_in <= 1'b1;
    hold_keys(11000);
    chk("up first", 32'h0, {31'h0, cfg_mode});
    {mode_key_in, up1_key_in} <= 2'b00;
    hold_keys(3);
    mode_key_in <= 1'b1;
    hold_keys(2);
    up1_key_in <= 1'b1;
    hold_keys(10100);
    {mode_key_in, up1_key_in} <= 2'b00;
    chk("cfg entry", 32'h1, {31'h0, cfg_mode});
    rd("cfg meas", OFS_MEAS, 32'h0);
    outs(3'b000);
    wr(OFS_CTRL, 32'h0);
    rd("pending", OFS_PEND, 32'h0);
    rd("ctrl held", OFS_CTRL, 32'h1);
    wr(OFS_SV1, 32'h64);
    mode_key_in <= 1'b1;
    hold_keys(5);
    mode_key_in <= 1'b0;
    hold_keys(3);
    chk("cfg exit", 32'h0, {31'h0, cfg_mode});
    rd("sv1 reinit", OFS_SV1, 32'h3e8);
    rd("ctrl applied", OFS_CTRL, 32'h0);
    // continuous gate, upper-upper mode with peak hold
    wr(OFS_CTRL, 32'h304);
    on_ms <= 1;
    off_ms <= 1;
    sen_en <= 1'b1;
    wr(OFS_SV1, 32'h190);
    hold_keys(400);
    rd("meas cont", OFS_MEAS, 32'h1f4);
    outs(3'b110);
    wr(OFS_HYST, 32'h1e);
    wr(OFS_SV1, 32'h208);
    outs(3'b110);
    wr(OFS_OFFDLY, 32'h5);
    wr(OFS_SV1, 32'h258);
    outs(3'b110);
    hold_keys(100);
    outs(3'b010);
    hold_keys(2600);
    rd("run time", OFS_RUNTIME, 32'h1);
    // supply dip: held peak must survive, outputs held off again
    nrst <= 1'b0;
    hold_keys(3);
    nrst <= 1'b1;
    rd("peak kept", OFS_PEAK, 32'h1f4);
    outs(3'b000);
    stop_test();
  end
endmodule
